// file: design/gpio_port_consts.vh
/*
  Constants for the general-purpose I/O port: register indices, implemented-pin masks,
  reset values. Assumes inclusion by bare name from the port design files.
*/
`ifndef GPIO_PORT_CONSTS_VH
`define GPIO_PORT_CONSTS_VH

`define REG_PIN_LEVEL       4'h0
`define REG_OUTPUT_LATCH    4'h1
`define REG_DIRECTION       4'h2
`define REG_ANALOG_SELECT   4'h3
`define REG_PULL_UP         4'h4
`define REG_OPEN_DRAIN      4'h5
`define REG_SLEW_LIMIT      4'h6
`define REG_INPUT_THRESHOLD 4'h7

`define GROUP_A_MASK        8'h3f
`define GROUP_B_MASK        8'hf0
`define GROUP_C_MASK_WIDE   8'hff
`define GROUP_C_MASK_NARROW 8'h3f

`define RST_DIRECTION       8'hff
`define RST_ANALOG_SELECT   8'hff
`define RST_ZERO            8'h00
`define RST_THRESHOLD       8'hff

`endif

// file: design/port_group.v
/*
  One eight-bit port group: control registers, output latch, pin
  synchroniser and pin-function priority. Assumes a single-cycle write
  strobe and an unimplemented-bit mask tied to a constant.
*/
`timescale 1ns/1ps
`include "gpio_port_consts.vh"

module port_group
(
    input  wire       clock,
    input  wire       sys_rst,
    input  wire [7:0] impl_mask,
    input  wire       wr_en,
    input  wire [3:0] wr_sel,
    input  wire [7:0] wr_data,
    input  wire [3:0] rd_sel,
    output reg  [7:0] rd_data_ff,
    input  wire [7:0] pin_in,
    output reg  [7:0] pin_out_ff,
    output reg  [7:0] pin_oe_n_ff,
    output reg  [7:0] pull_up_ff,
    output reg  [7:0] slew_limit_ff,
    output reg  [7:0] threshold_ff,
    input  wire [7:0] cfg_override,
    input  wire [7:0] cfg_out,
    input  wire [7:0] cfg_oe,
    input  wire [7:0] analog_out_en,
    input  wire [7:0] periph_en,
    input  wire [7:0] periph_out,
    input  wire [7:0] periph_oe,
    input  wire [7:0] serial_od,
    output reg  [7:0] digital_in
);

    reg [7:0] output_latch_ff;
    reg [7:0] direction_ff;
    reg [7:0] analog_select_ff;
    reg [7:0] open_drain_ff;
    reg [7:0] sync1_ff;
    reg [7:0] nxt_out;
    reg [7:0] nxt_oe_n;
    reg [7:0] nxt_rd;

    ////////////////////////////////////////////////////////////////////////////

    always @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            output_latch_ff  <= `RST_ZERO;
            direction_ff     <= `RST_DIRECTION;
            analog_select_ff <= `RST_ANALOG_SELECT;
            open_drain_ff    <= `RST_ZERO;
            pull_up_ff       <= `RST_ZERO;
            slew_limit_ff    <= `RST_ZERO;
            threshold_ff     <= `RST_THRESHOLD;
        end
        else if (wr_en)
        begin
            case (wr_sel)
                `REG_PIN_LEVEL, `REG_OUTPUT_LATCH:
                    output_latch_ff <= wr_data & impl_mask;
                `REG_DIRECTION:       direction_ff     <= wr_data & impl_mask;
                `REG_ANALOG_SELECT:   analog_select_ff <= wr_data & impl_mask;
                `REG_PULL_UP:         pull_up_ff       <= wr_data & impl_mask;
                `REG_OPEN_DRAIN:      open_drain_ff    <= wr_data & impl_mask;
                `REG_SLEW_LIMIT:      slew_limit_ff    <= wr_data & impl_mask;
                `REG_INPUT_THRESHOLD: threshold_ff     <= wr_data & impl_mask;
                default:              output_latch_ff  <= output_latch_ff;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Second stage only feeds logic; first stage sees nothing else

    always @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sync1_ff   <= `RST_ZERO;
            digital_in <= `RST_ZERO;
        end
        else
        begin
            sync1_ff   <= pin_in;
            // Masking in the second stage keeps the output a flop
            digital_in <= sync1_ff & ~analog_select_ff & impl_mask;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-pin output priority

    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1)
        begin : g_pin
            always @*
            begin
                nxt_out[i]  = output_latch_ff[i];
                nxt_oe_n[i] = direction_ff[i];
                if (!impl_mask[i])
                begin
                    nxt_out[i]  = 1'b0;
                    nxt_oe_n[i] = 1'b1;
                end
                else if (cfg_override[i])
                begin
                    nxt_out[i]  = cfg_out[i];
                    nxt_oe_n[i] = ~cfg_oe[i];
                end
                else if (analog_out_en[i])
                begin
                    nxt_out[i]  = 1'b0;
                    nxt_oe_n[i] = 1'b1;
                end
                else if (periph_en[i])
                begin
                    nxt_out[i]  = periph_out[i];
                    nxt_oe_n[i] = ~periph_oe[i];
                    if (serial_od[i] && periph_out[i])
                        nxt_oe_n[i] = 1'b1;
                end
                // Sink only: released instead of driven high
                if ((open_drain_ff[i] && !cfg_override[i]) && nxt_out[i])
                    nxt_oe_n[i] = 1'b1;
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////

    always @*
    begin
        case (rd_sel)
            `REG_PIN_LEVEL:       nxt_rd = digital_in;
            `REG_OUTPUT_LATCH:    nxt_rd = output_latch_ff;
            `REG_DIRECTION:       nxt_rd = direction_ff;
            `REG_ANALOG_SELECT:   nxt_rd = analog_select_ff;
            `REG_PULL_UP:         nxt_rd = pull_up_ff;
            `REG_OPEN_DRAIN:      nxt_rd = open_drain_ff;
            `REG_SLEW_LIMIT:      nxt_rd = slew_limit_ff;
            `REG_INPUT_THRESHOLD: nxt_rd = threshold_ff;
            default:              nxt_rd = `RST_ZERO;
        endcase
    end

    always @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rd_data_ff  <= `RST_ZERO;
            pin_out_ff  <= `RST_ZERO;
            pin_oe_n_ff <= 8'hff;
        end
        else
        begin
            rd_data_ff  <= nxt_rd;
            pin_out_ff  <= nxt_out;
            pin_oe_n_ff <= nxt_oe_n;
        end
    end

endmodule

// file: design/general_purpose_io_port.v
/*
  Top of the I/O port: three groups A, B, C with group select on the
  register port. Assumes the CPU gives a one-cycle write strobe and that
  pins are three signals each, resolved outside.
*/
`timescale 1ns/1ps
`include "gpio_port_consts.vh"

module general_purpose_io_port
#(
    parameter HAS_GROUP_B   = 1,
    parameter WIDE_GROUP_C  = 1
)
(
    input  wire        clock,
    input  wire        sys_rst,
    input  wire        wr_en,
    input  wire [1:0]  grp_sel,
    input  wire [3:0]  reg_sel,
    input  wire [7:0]  wr_data,
    output reg  [7:0]  rd_data_ff,
    input  wire [23:0] pin_in,
    output wire [23:0] pin_out_ff,
    output wire [23:0] pin_oe_n_ff,
    output wire [23:0] pull_up_ff,
    output wire [23:0] slew_limit_ff,
    output wire [23:0] threshold_ff,
    input  wire [23:0] cfg_override,
    input  wire [23:0] cfg_out,
    input  wire [23:0] cfg_oe,
    input  wire [23:0] analog_out_en,
    input  wire [23:0] periph_en,
    input  wire [23:0] periph_out,
    input  wire [23:0] periph_oe,
    input  wire [23:0] serial_od,
    output wire [23:0] digital_in
);

    wire [23:0] grp_rd;
    wire [23:0] masks;

    // Variant masks; absent group B is all unimplemented
    assign masks[7:0]   = `GROUP_A_MASK;
    assign masks[15:8]  = (HAS_GROUP_B != 0) ? `GROUP_B_MASK : 8'h00;
    assign masks[23:16] = (WIDE_GROUP_C != 0) ? `GROUP_C_MASK_WIDE : `GROUP_C_MASK_NARROW;

    ////////////////////////////////////////////////////////////////////////////

    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1)
        begin : g_grp
            port_group u_grp
            (
                .clock         (clock),
                .sys_rst       (sys_rst),
                .impl_mask     (masks[g*8 +: 8]),
                .wr_en         (wr_en && (grp_sel == g)),
                .wr_sel        (reg_sel),
                .wr_data       (wr_data),
                .rd_sel        (reg_sel),
                .rd_data_ff    (grp_rd[g*8 +: 8]),
                .pin_in        (pin_in[g*8 +: 8]),
                .pin_out_ff    (pin_out_ff[g*8 +: 8]),
                .pin_oe_n_ff   (pin_oe_n_ff[g*8 +: 8]),
                .pull_up_ff    (pull_up_ff[g*8 +: 8]),
                .slew_limit_ff (slew_limit_ff[g*8 +: 8]),
                .threshold_ff  (threshold_ff[g*8 +: 8]),
                .cfg_override  (cfg_override[g*8 +: 8]),
                .cfg_out       (cfg_out[g*8 +: 8]),
                .cfg_oe        (cfg_oe[g*8 +: 8]),
                .analog_out_en (analog_out_en[g*8 +: 8]),
                .periph_en     (periph_en[g*8 +: 8]),
                .periph_out    (periph_out[g*8 +: 8]),
                .periph_oe     (periph_oe[g*8 +: 8]),
                .serial_od     (serial_od[g*8 +: 8]),
                .digital_in    (digital_in[g*8 +: 8])
            );
        end
    endgenerate

    // Extra stage so the read port comes straight from a flop
    always @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            rd_data_ff <= 8'h00;
        else
        begin
            case (grp_sel)
                2'h0:    rd_data_ff <= grp_rd[7:0];
                2'h1:    rd_data_ff <= grp_rd[15:8];
                2'h2:    rd_data_ff <= grp_rd[23:16];
                default: rd_data_ff <= 8'h00;
            endcase
        end
    end

endmodule

// file: verification/gpio_port_props.sv
/*
  Pin-side assertions for the I/O port top, bound to it.
  Assumes one clock, async active-high reset; group B and C masks taken from HAS_GROUP_B, WIDE_GROUP_C.
*/
`timescale 1ns/1ps
module gpio_port_props
#(
    parameter HAS_GROUP_B  = 1,
    parameter WIDE_GROUP_C = 1
)
(
    input wire        clock,
    input wire        sys_rst,
    input wire        wr_en,
    input wire [23:0] pin_in,
    input wire [23:0] pin_out_ff,
    input wire [23:0] pin_oe_n_ff,
    input wire [23:0] pull_up_ff,
    input wire [23:0] slew_limit_ff,
    input wire [23:0] threshold_ff,
    input wire [23:0] cfg_override,
    input wire [23:0] cfg_out,
    input wire [23:0] cfg_oe,
    input wire [23:0] analog_out_en,
    input wire [23:0] periph_en,
    input wire [23:0] periph_out,
    input wire [23:0] periph_oe,
    input wire [23:0] serial_od,
    input wire [23:0] digital_in
);
    localparam [23:0] IMPL = {(WIDE_GROUP_C != 0) ? 8'hff : 8'h3f,
                              (HAS_GROUP_B != 0) ? 8'hf0 : 8'h00, 8'h3f};
    reg [1:0] age_ff;
    ////////////////////////////////////////////////////////////////////////////////
    // Past values are meaningless until pipes refill after reset
    always @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            age_ff <= 2'h0;
        else if (age_ff != 2'h3)
            age_ff <= age_ff + 2'h1;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////////////////////
    a_cfg_wins: assert property (age_ff == 2'h3 |->
        ((~pin_oe_n_ff ^ $past(cfg_oe)) & $past(cfg_override) & IMPL) == 24'h0 &&
        ((pin_out_ff ^ $past(cfg_out)) & $past(cfg_override & cfg_oe) & IMPL) == 24'h0)
        else $error("config override not obeyed");
    a_analog_hiz: assert property (age_ff == 2'h3 |->
        (~pin_oe_n_ff & $past(analog_out_en & ~cfg_override)) == 24'h0)
        else $error("driver on under analog output");
    a_unimpl_idle: assert property (((~pin_oe_n_ff | digital_in) & ~IMPL) == 24'h0)
        else $error("unimplemented pin active");
    a_sync_lag: assert property (age_ff == 2'h3 |->
        (digital_in & ~$past(pin_in, 2)) == 24'h0)
        else $error("digital input not from pin two cycles back");
    a_serial_od: assert property (age_ff == 2'h3 |->
        (~pin_oe_n_ff & pin_out_ff & $past(serial_od & periph_en & ~cfg_override)) == 24'h0)
        else $error("serial pin driven high");
    a_periph_out: assert property (age_ff == 2'h3 |->
        ((pin_out_ff ^ $past(periph_out)) & ~pin_oe_n_ff & IMPL &
         $past(periph_en & ~cfg_override & ~analog_out_en)) == 24'h0)
        else $error("peripheral level not on pin");
    a_periph_block: assert property (age_ff == 2'h3 |->
        (~pin_oe_n_ff & $past(periph_en & ~periph_oe & ~cfg_override) & IMPL) == 24'h0)
        else $error("latch drives peripheral pin");
    a_ctrl_hold: assert property (!wr_en && !$past(wr_en) && !$past(wr_en, 2) |->
        $stable(pull_up_ff) && $stable(slew_limit_ff) && $stable(threshold_ff))
        else $error("pin control changed without write");
endmodule
bind general_purpose_io_port gpio_port_props #(.HAS_GROUP_B(HAS_GROUP_B),
    .WIDE_GROUP_C(WIDE_GROUP_C)) props (.clock(clock), .sys_rst(sys_rst), .wr_en(wr_en),
    .pin_in(pin_in), .pin_out_ff(pin_out_ff), .pin_oe_n_ff(pin_oe_n_ff),
    .pull_up_ff(pull_up_ff), .slew_limit_ff(slew_limit_ff), .threshold_ff(threshold_ff),
    .cfg_override(cfg_override), .cfg_out(cfg_out), .cfg_oe(cfg_oe),
    .analog_out_en(analog_out_en), .periph_en(periph_en), .periph_out(periph_out),
    .periph_oe(periph_oe), .serial_od(serial_od), .digital_in(digital_in));

// file: verification/pin_model.sv
/*
  Pads and outside world: resolves each pin from port drive, outside drive
  and weak pull-up. Assumes oe_n low means the port drives.
*/
`timescale 1ns/1ps
module pin_model
(
    input  wire        clock,
    input  wire [23:0] pin_out_ff,
    input  wire [23:0] pin_oe_n_ff,
    input  wire [23:0] pull_up_ff,
    input  wire [23:0] ext_en,
    input  wire [23:0] ext_val,
    output wire [23:0] pin_in
);
    reg [23:0] last_ff = 24'h0;
    // Floating pins toggle so a stale level never passes for a read
    assign pin_in = (~pin_oe_n_ff & pin_out_ff) | (pin_oe_n_ff & ext_en & ext_val)
        | (pin_oe_n_ff & ~ext_en & (pull_up_ff | ~last_ff));
    always @(posedge clock)
        last_ff <= pin_in;
endmodule

// file: verification/general_purpose_io_port_tb_top.sv
/*
  Self-checking bench for the I/O port top with a register model.
  Assumes the read and pin latencies given by the designer.
*/
`timescale 1ns/1ps
module general_purpose_io_port_tb_top;
    reg clock = 1'b0, sys_rst = 1'b1, wr_en = 1'b0;
    reg [1:0] grp_sel = 2'h0;
    reg [3:0] reg_sel = 4'h0;
    reg [7:0] wr_data = 8'h0;
    reg [23:0] co = 24'h0, cd = 24'h0, ce = 24'h0, ao = 24'h0, pe = 24'h0, pd = 24'h0;
    reg [23:0] pq = 24'h0, so = 24'h0, ext_val = 24'h0;
    wire [7:0] rd_data_ff;
    wire [23:0] pin_in, pin_out_ff, pin_oe_n_ff, pull_up_ff, slew_limit_ff, threshold_ff, dig;
    reg [7:0] m [0:2][0:7];
    reg [7:0] im [0:2];
    integer err_count = 0, checks_done = 0, i, g, r;
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        forever #20 clock = ~clock;
    end
    general_purpose_io_port dut (.clock(clock), .sys_rst(sys_rst), .wr_en(wr_en),
        .grp_sel(grp_sel), .reg_sel(reg_sel), .wr_data(wr_data), .rd_data_ff(rd_data_ff),
        .pin_in(pin_in), .pin_out_ff(pin_out_ff), .pin_oe_n_ff(pin_oe_n_ff),
        .pull_up_ff(pull_up_ff), .slew_limit_ff(slew_limit_ff), .threshold_ff(threshold_ff),
        .cfg_override(co), .cfg_out(cd), .cfg_oe(ce), .analog_out_en(ao), .periph_en(pe),
        .periph_out(pd), .periph_oe(pq), .serial_od(so), .digital_in(dig));
    pin_model pads (.clock(clock), .pin_out_ff(pin_out_ff), .pin_oe_n_ff(pin_oe_n_ff),
        .pull_up_ff(pull_up_ff), .ext_en(24'hffffff), .ext_val(ext_val), .pin_in(pin_in));
    ////////////////////////////////////////////////////////////////////////////////
    function [23:0] vec(input integer k);
        vec = {m[2][k], m[1][k], m[0][k]};
    endfunction
    task check(input [23:0] exp, input [23:0] got);
    begin
        checks_done = checks_done + 1;
        if (got !== exp)
        begin
            err_count = err_count + 1;
            $display("Error at %0t: expected %h got %h", $time, exp, got);
        end
    end
    endtask
    task wr(input integer gg, input integer rr, input [7:0] d);
    begin
        @(negedge clock);
        {wr_en, grp_sel, reg_sel, wr_data} = {1'b1, gg[1:0], rr[3:0], d};
        @(negedge clock);
        wr_en = 1'b0;
        if (gg < 3 && rr < 8)
            m[gg][(rr == 0) ? 1 : rr] = d & im[gg];
    end
    endtask
    task rd(input integer gg, input integer rr);
        reg [7:0] e, k;
    begin
        @(negedge clock);
        {grp_sel, reg_sel} = {gg[1:0], rr[3:0]};
        repeat (2) @(negedge clock);
        k = (gg > 2 || rr == 0 || rr > 7) ? 8'hff : im[gg];
        e = (gg > 2 || rr > 7) ? 8'h0 : m[gg][rr];
        if (gg < 3 && rr == 0)
            e = pin_in[gg*8+:8] & ~m[gg][3] & im[gg];
        check({16'h0, e}, {16'h0, rd_data_ff & k});
    end
    endtask
    task chk_pins;
        reg [23:0] drv;
    begin
        drv = ~vec(2) & {im[2], im[1], im[0]} & ~(vec(5) & vec(1));
        check(~drv, pin_oe_n_ff);
        check(vec(1) & drv, pin_out_ff & drv);
        check(vec(4), pull_up_ff & {im[2], im[1], im[0]});
        check(vec(6), slew_limit_ff & {im[2], im[1], im[0]});
        check(vec(7), threshold_ff & {im[2], im[1], im[0]});
    end
    endtask
    task finish_test;
    begin
        $display("Checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #400000;
        err_count = err_count + 1;
        finish_test;
    end
    initial
    begin
        {im[0], im[1], im[2]} = {8'h3f, 8'hf0, 8'hff};
        for (g = 0; g < 3; g = g + 1)
            for (r = 0; r < 8; r = r + 1)
                m[g][r] = (r == 2 || r == 3 || r == 7) ? im[g] : 8'h0;
        i = $urandom(72);
        repeat (8) @(posedge clock);
        @(negedge clock);
        sys_rst = 1'b0;
        for (g = 0; g < 4; g = g + 1)
            for (r = 0; r < 10; r = r + 1)
                rd(g, r);
        chk_pins;
        for (i = 0; i < 120; i = i + 1)
        begin
            g = $urandom % 4;
            r = $urandom % 10;
            wr(g, r, $urandom);
            ext_val = $urandom;
            repeat (6) @(negedge clock);
            chk_pins;
            rd(g, (i % 2) ? 1 : $urandom % 8);
        end
        // Overrides are judged by the bound assertions only
        for (i = 0; i < 200; i = i + 1)
        begin
            @(negedge clock);
            {co, cd, ce, ao} = {$urandom & $urandom, $urandom, $urandom, $urandom & $urandom};
            {pe, pd, pq, so} = {$urandom, $urandom, $urandom, $urandom & $urandom};
            // Thresholds stay untouched while peripherals run
            if (i % 9 == 0)
                wr($urandom % 3, 2 + $urandom % 4, $urandom);
        end
        finish_test;
    end
endmodule
